// >>> rtl/atfc_top.sv
// ascii text to single precision float converter: fetch, parse, scale, store
`timescale 1ns/1ps
module atfc_top #(
  parameter int ADDR_W     = 4,
  parameter int MAX_CHARS  = atfc_pkg::MAX_CHARS,
  parameter int SIG_DIGITS = atfc_pkg::SIG_DIGITS
) (
  // clock, reset, enable
  input  wire logic              CLK_I,
  input  wire logic              SYS_RST_I,
  input  wire logic              CE_I,
  // operation control
  input  wire logic              START_I,
  output logic                   BUSY_O,
  output logic                   DONE_O,
  // source word reads
  output logic                   SRC_RD_O,
  output logic [ADDR_W-1:0]      SRC_ADDR_O,
  input  wire logic              SRC_VALID_I,
  input  wire logic [15:0]       SRC_DATA_I,
  // destination word writes
  output logic                   DST_WR_O,
  output logic                   DST_SEL_O,
  output logic [15:0]            DST_DATA_O,
  // result flags
  output logic                   ERROR_FLAG_OUT_O,
  output logic                   ZERO_RESULT_FLAG_O
);
  if (MAX_CHARS < 2 || MAX_CHARS > 31 || (2 ** ADDR_W) * 2 < MAX_CHARS)
    $error("atfc_top: MAX_CHARS or ADDR_W out of range");
  if (SIG_DIGITS < 1 || SIG_DIGITS > 6)
    $error("atfc_top: SIG_DIGITS must be 1 to 6");

  function automatic logic is_dig(input logic [7:0] ch);
    return ch >= atfc_pkg::CH_DIG_LO && ch <= atfc_pkg::CH_DIG_HI;
  endfunction

  localparam int DEXP_LIM = atfc_pkg::DEXP_LIM;

  atfc_if sif ();

  atfc_pkg::atfc_state_t st, next_st;
  atfc_pkg::atfc_phase_t ph, next_ph;
  logic [15:0]       word, next_word;
  logic              hi_sel, next_hi_sel;
  logic [4:0]        cnt, next_cnt;
  logic [ADDR_W-1:0] widx, next_widx;
  logic [19:0]       mant, next_mant;
  logic [2:0]        ndig, next_ndig;
  logic [2:0]        fcnt, next_fcnt;
  logic [4:0]        drop, next_drop;
  logic [6:0]        eacc, next_eacc;
  logic              eneg, next_eneg;
  logic              neg, next_neg;
  logic signed [7:0] dexp, next_dexp;
  logic              start, next_start;
  logic [31:0]       res, next_res;
  logic              zpend, next_zpend;
  logic [15:0]       dout, next_dout;
  logic              err_f, next_err_f;
  logic              zero_f, next_zero_f;
  logic              done, next_done;
  logic [7:0]        c;
  logic              fin, bad;
  logic [10:0]       etmp;
  logic signed [9:0] dx;

  assign c = hi_sel ? word[15:8] : word[7:0]; // RULE2

  always_comb begin
    next_st = st; next_ph = ph; next_word = word; next_hi_sel = hi_sel;
    next_cnt = cnt; next_widx = widx; next_mant = mant; next_ndig = ndig;
    next_fcnt = fcnt; next_drop = drop; next_eacc = eacc; next_eneg = eneg;
    next_neg = neg; next_dexp = dexp; next_start = 1'b0; next_res = res;
    next_zpend = zpend; next_dout = dout; next_err_f = err_f;
    next_zero_f = zero_f; next_done = 1'b0;
    fin = 1'b0;
    bad = 1'b0;
    etmp = {4'h0, eacc} * 11'd10 + {7'h0, c[3:0]};
    dx = (eneg ? -$signed({3'h0, eacc}) : $signed({3'h0, eacc}))
         + $signed({5'h0, drop}) - $signed({7'h0, fcnt});
    unique case (st)
      atfc_pkg::ST_IDLE: if (START_I) begin
        next_st = atfc_pkg::ST_FETCH; next_ph = atfc_pkg::PH_LEAD;
        next_cnt = 5'h0; next_widx = '0; next_mant = 20'h0; next_ndig = 3'h0;
        next_fcnt = 3'h0; next_drop = 5'h0; next_eacc = 7'h0;
        next_eneg = 1'b0; next_neg = 1'b0;
      end
      atfc_pkg::ST_FETCH: if (SRC_VALID_I) begin
        next_word   = SRC_DATA_I;
        next_hi_sel = 1'b1; // RULE2
        next_st     = atfc_pkg::ST_CHAR;
      end
      atfc_pkg::ST_CHAR: begin
        if (c == atfc_pkg::CH_TERM) begin
          fin = 1'b1; // RULE3
          // empty text, no digit at all, or a dangling exponent letter
          bad = cnt == 5'h0 || (ndig == 3'h0 && drop == 5'h0) // RULE14
                || ph == atfc_pkg::PH_ESIGN; // RULE11
        end else if (cnt == 5'(MAX_CHARS - 1)) begin
          fin = 1'b1; // RULE4
          bad = 1'b1;
        end else if (c == atfc_pkg::CH_SPACE) begin
          // skipped anywhere; a leading one leaves the sign positive
          next_ph = ph; // RULE6
        end else if (is_dig(c) && (ph == atfc_pkg::PH_LEAD || ph == atfc_pkg::PH_INT
                                   || ph == atfc_pkg::PH_FRAC)) begin
          if (ndig < 3'(SIG_DIGITS)) begin
            next_mant = 20'(mant * 20'd10 + {16'h0, c[3:0]}); // RULE5
            next_ndig = ndig + 3'h1;
            if (ph == atfc_pkg::PH_FRAC) next_fcnt = fcnt + 3'h1; // RULE9
          end else if (ph != atfc_pkg::PH_FRAC) begin
            // dropped integer digits still scale the magnitude
            next_drop = drop + 5'h1; // RULE5
          end
          if (ph == atfc_pkg::PH_LEAD) next_ph = atfc_pkg::PH_INT;
        end else if (ph == atfc_pkg::PH_LEAD
                     && (c == atfc_pkg::CH_PLUS || c == atfc_pkg::CH_MINUS)) begin
          next_neg = c == atfc_pkg::CH_MINUS; // RULE7
          next_ph  = atfc_pkg::PH_INT;
        end else if ((ph == atfc_pkg::PH_LEAD || ph == atfc_pkg::PH_INT)
                     && c == atfc_pkg::CH_DOT) begin
          next_ph = atfc_pkg::PH_FRAC; // RULE9
        end else if ((ph == atfc_pkg::PH_INT || ph == atfc_pkg::PH_FRAC)
                     && c == atfc_pkg::CH_EXP) begin
          next_ph = atfc_pkg::PH_ESIGN; // RULE8
        end else if (ph == atfc_pkg::PH_ESIGN
                     && (c == atfc_pkg::CH_PLUS || c == atfc_pkg::CH_MINUS)) begin
          next_eneg = c == atfc_pkg::CH_MINUS; // RULE11
          next_ph   = atfc_pkg::PH_EDIG;
        end else if (ph == atfc_pkg::PH_EDIG && is_dig(c)) begin
          // saturates; anything that large already over- or underflows
          next_eacc = etmp > {4'h0, atfc_pkg::EXP_SAT} ? atfc_pkg::EXP_SAT : etmp[6:0];
        end else begin
          // stray character, bad exponent start or a second exponent
          fin = 1'b1; // RULE10 RULE11 RULE12
          bad = 1'b1;
        end
        if (!fin) begin
          next_cnt = cnt + 5'h1;
          if (hi_sel) begin
            next_hi_sel = 1'b0;
          end else begin
            next_widx = widx + 1'b1;
            next_st   = atfc_pkg::ST_FETCH;
          end
        end else if (bad) begin
          next_err_f  = 1'b1; // RULE16
          next_zero_f = 1'b0;
          next_done   = 1'b1;
          next_st     = atfc_pkg::ST_IDLE;
        end else begin
          if (dx > 10'(DEXP_LIM))
            next_dexp = 8'(DEXP_LIM);
          else if (dx < -10'(DEXP_LIM))
            next_dexp = -8'(DEXP_LIM);
          else
            next_dexp = dx[7:0];
          next_start = 1'b1;
          next_st    = atfc_pkg::ST_SCALE;
        end
      end
      atfc_pkg::ST_SCALE: if (sif.done) begin
        if (sif.ovf) begin
          next_err_f  = 1'b1; // RULE13
          next_zero_f = 1'b0;
          next_done   = 1'b1;
          next_st     = atfc_pkg::ST_IDLE;
        end else begin
          next_res   = sif.result;
          next_zpend = sif.zero;
          next_dout  = sif.result[15:0]; // RULE1
          next_st    = atfc_pkg::ST_WR_LO;
        end
      end
      atfc_pkg::ST_WR_LO: begin
        next_dout = res[31:16]; // RULE1
        next_st   = atfc_pkg::ST_WR_HI;
      end
      atfc_pkg::ST_WR_HI: begin
        next_err_f  = 1'b0; // RULE14
        next_zero_f = zpend; // RULE15
        next_done   = 1'b1;
        next_st     = atfc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      st <= atfc_pkg::ST_IDLE; ph <= atfc_pkg::PH_LEAD; word <= 16'h0;
      hi_sel <= 1'b0; cnt <= 5'h0; widx <= '0; mant <= 20'h0; ndig <= 3'h0;
      fcnt <= 3'h0; drop <= 5'h0; eacc <= 7'h0; eneg <= 1'b0; neg <= 1'b0;
      dexp <= 8'sd0; start <= 1'b0; res <= 32'h0; zpend <= 1'b0;
      dout <= 16'h0; err_f <= 1'b0; zero_f <= 1'b0; done <= 1'b0;
    end else if (CE_I) begin
      st <= next_st; ph <= next_ph; word <= next_word; hi_sel <= next_hi_sel;
      cnt <= next_cnt; widx <= next_widx; mant <= next_mant; ndig <= next_ndig;
      fcnt <= next_fcnt; drop <= next_drop; eacc <= next_eacc;
      eneg <= next_eneg; neg <= next_neg; dexp <= next_dexp;
      start <= next_start; res <= next_res; zpend <= next_zpend;
      dout <= next_dout; err_f <= next_err_f; zero_f <= next_zero_f;
      done <= next_done;
    end
  end

  assign sif.start = start;
  assign sif.mant  = mant;
  assign sif.dexp  = dexp;
  assign sif.neg   = neg;

  atfc_scale u_scale (
    .clk_i (CLK_I),
    .rst_i (SYS_RST_I),
    .ce_i  (CE_I),
    .sif   (sif)
  );

  assign BUSY_O             = st != atfc_pkg::ST_IDLE;
  assign DONE_O             = done;
  assign SRC_RD_O           = st == atfc_pkg::ST_FETCH;
  assign SRC_ADDR_O         = widx;
  assign DST_WR_O           = st == atfc_pkg::ST_WR_LO || st == atfc_pkg::ST_WR_HI;
  assign DST_SEL_O          = st == atfc_pkg::ST_WR_HI;
  assign DST_DATA_O         = dout;
  assign ERROR_FLAG_OUT_O   = err_f;
  assign ZERO_RESULT_FLAG_O = zero_f;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  logic in_char;
  assign in_char = st == atfc_pkg::ST_CHAR && CE_I;

  a_byte_order_hi: assert property ( // RULE2
    SRC_RD_O && SRC_VALID_I && CE_I |=> c == $past(SRC_DATA_I[15:8]))
    else $error("high byte not taken first");
  a_term_stops: assert property ( // RULE3
    in_char && c == atfc_pkg::CH_TERM |=> st != atfc_pkg::ST_CHAR && !SRC_RD_O)
    else $error("scan went on past terminator");
  a_char_limit: assert property ( // RULE4
    in_char && c != atfc_pkg::CH_TERM && cnt == 5'(MAX_CHARS - 1) |=> err_f && done)
    else $error("missing terminator not flagged");
  a_digit_cap: assert property ( // RULE5
    in_char && ndig == 3'(SIG_DIGITS) |=> $stable(mant))
    else $error("digit beyond limit changed mantissa");
  a_bad_digit: assert property ( // RULE10
    in_char && ph == atfc_pkg::PH_INT && c > atfc_pkg::CH_DIG_HI
    && c != atfc_pkg::CH_EXP |=> err_f)
    else $error("non-digit in integer part not flagged");
  a_byte_order_lo: assert property ( // RULE2
    in_char && hi_sel |=> st != atfc_pkg::ST_CHAR || c == $past(word[7:0]))
    else $error("low byte not taken second");
  a_space_skip: assert property ( // RULE6
    in_char && c == atfc_pkg::CH_SPACE |=> $stable(mant) && $stable(neg) && $stable(ph))
    else $error("space changed the parse");
  a_lead_sign: assert property ( // RULE7
    in_char && ph == atfc_pkg::PH_LEAD && cnt != 5'(MAX_CHARS - 1)
    && (c == atfc_pkg::CH_PLUS || c == atfc_pkg::CH_MINUS)
    |=> neg == ($past(c) == atfc_pkg::CH_MINUS))
    else $error("leading sign not taken");
  a_frac_count: assert property ( // RULE9
    in_char && ph == atfc_pkg::PH_FRAC && is_dig(c) && ndig < 3'(SIG_DIGITS)
    && cnt != 5'(MAX_CHARS - 1) |=> fcnt == $past(fcnt) + 3'h1)
    else $error("fraction digit not counted");
  a_dexp_clamp: assert property ( // RULE9
    start |-> dexp <= DEXP_LIM && dexp >= -DEXP_LIM)
    else $error("decimal scale out of range");
  a_exp_sign: assert property ( // RULE11
    in_char && ph == atfc_pkg::PH_ESIGN && is_dig(c) |=> err_f && done)
    else $error("exponent without sign not flagged");
  a_two_exp: assert property ( // RULE12
    in_char && ph == atfc_pkg::PH_EDIG && c == atfc_pkg::CH_EXP |=> err_f)
    else $error("second exponent not flagged");
  a_ovf_err: assert property ( // RULE13
    st == atfc_pkg::ST_SCALE && sif.done && sif.ovf && CE_I |=> err_f && !DST_WR_O)
    else $error("overflow not flagged");
  a_empty_err: assert property ( // RULE14
    in_char && cnt == 5'h0 && c == atfc_pkg::CH_TERM |=> err_f && !zero_f)
    else $error("empty text not flagged");
  a_write_pair: assert property ( // RULE1
    DST_WR_O && !DST_SEL_O && CE_I |=> DST_WR_O && DST_SEL_O ##1 done && !err_f)
    else $error("destination pair broken");
  a_neg_sign: assert property ( // RULE7
    DST_WR_O && DST_SEL_O && neg |-> DST_DATA_O[15] || zpend)
    else $error("negative text gave positive result");
  a_zero_flag: assert property ( // RULE15
    DST_WR_O && DST_SEL_O && CE_I |=> zero_f == (res[30:0] == 31'h0))
    else $error("zero flag disagrees with result");
  a_err_nowrite: assert property ( // RULE16
    done && err_f |-> $past(!DST_WR_O) && !zero_f)
    else $error("write or zero flag alongside error");

  c_ok_done:  cover property (done && !err_f && !zero_f);
  c_zero:     cover property (done && zero_f);
  c_error:    cover property (done && err_f);
  c_negative: cover property (DST_WR_O && DST_SEL_O && DST_DATA_O[15]);
  c_exp_form: cover property (in_char && ph == atfc_pkg::PH_EDIG);
endmodule

// >>> pkg/atfc_pkg.sv
// package: constants, states and phases of the ascii to float converter
// Function
// (RULE1) The converter turns the text read from source words into a 32-bit float written to two destination words.
// (RULE2) Characters are taken high byte first, then low byte, word after word.
// (RULE3) Scanning starts at the first character and stops at the first 00 hex byte.
// (RULE4) A terminator must lie within the first 25 characters, otherwise the error flag is set.
// (RULE5) Only the first 6 digits count; sign, point and exponent do not, and later digits are dropped.
// (RULE6) Spaces are skipped and do not change the value.
// (RULE7) A leading space or plus means positive, a leading minus gives a negative result.
// (RULE8) Decimal or exponent form is recognised from the text alone.
// (RULE9) Exponent form has integer, fraction and exponent parts; decimal form has integer and fraction.
// (RULE10) A non-digit in the integer or fraction digit positions sets the error flag.
// (RULE11) An exponent that does not start with E followed by plus or minus sets the error flag.
// (RULE12) A second exponent field sets the error flag.
// (RULE13) A result that overflows to infinity sets the error flag.
// (RULE14) Empty text sets the error flag, and the flag clears when nothing is wrong.
// (RULE15) The zero flag is set for a zero result and cleared for any other.
// (RULE16) On any error the destination words are left alone and only the error flag is raised.
package atfc_pkg;
  localparam logic [7:0]  CH_TERM    = 8'h00;
  localparam logic [7:0]  CH_SPACE   = 8'h20;
  localparam logic [7:0]  CH_PLUS    = 8'h2b;
  localparam logic [7:0]  CH_MINUS   = 8'h2d;
  localparam logic [7:0]  CH_DOT     = 8'h2e;
  localparam logic [7:0]  CH_EXP     = 8'h45;
  localparam logic [7:0]  CH_DIG_LO  = 8'h30;
  localparam logic [7:0]  CH_DIG_HI  = 8'h39;
  localparam int          MAX_CHARS  = 25;
  localparam int          SIG_DIGITS = 6;
  localparam logic [6:0]  EXP_SAT    = 7'h7f;
  localparam int          DEXP_LIM   = 64;
  localparam logic [9:0]  FLT_BIAS   = 10'h07f;
  localparam logic [9:0]  FLT_EMAX   = 10'h0ff;
  localparam logic [31:0] MUL_TENTH  = 32'hcccccccd;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_FETCH = 6'h02,
    ST_CHAR  = 6'h04,
    ST_SCALE = 6'h08,
    ST_WR_LO = 6'h10,
    ST_WR_HI = 6'h20
  } atfc_state_t;

  typedef enum logic [4:0] {
    PH_LEAD  = 5'h01,
    PH_INT   = 5'h02,
    PH_FRAC  = 5'h04,
    PH_ESIGN = 5'h08,
    PH_EDIG  = 5'h10
  } atfc_phase_t;

  typedef enum logic [2:0] {
    SC_IDLE = 3'h1,
    SC_STEP = 3'h2,
    SC_PACK = 3'h4
  } atfc_scst_t;
endpackage

// >>> pkg/atfc_if.sv
// interface: parser to scaler hand-over of mantissa, decimal exponent and result
`timescale 1ns/1ps
interface atfc_if;
  logic              start;
  logic [19:0]       mant;
  logic signed [7:0] dexp;
  logic              neg;
  logic              done;
  logic [31:0]       result;
  logic              ovf;
  logic              zero;
  modport main  (output start, mant, dexp, neg, input done, result, ovf, zero);
  modport scale (input start, mant, dexp, neg, output done, result, ovf, zero);
endinterface

// >>> rtl/atfc_scale.sv
// scaler: mantissa times ten to a power, packed as a single precision float
`timescale 1ns/1ps
module atfc_scale (
  // clock and control
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  // parser side
  atfc_if.scale     sif
);
  atfc_pkg::atfc_scst_t sc, next_sc;
  logic [31:0]       m, next_m;
  logic signed [9:0] e, next_e;
  logic signed [7:0] k, next_k;
  logic              neg, next_neg;
  logic [31:0]       result, next_result;
  logic              ovf, next_ovf, zero, next_zero, done, next_done;
  logic [35:0]       p10;
  logic [63:0]       p01;
  logic [24:0]       rnd;
  logic signed [9:0] be;
  logic [4:0]        msb;

  // one decade per cycle keeps the multiplier small; truncation costs under one ulp
  always_comb begin
    next_sc = sc; next_m = m; next_e = e; next_k = k; next_neg = neg;
    next_result = result; next_ovf = ovf; next_zero = zero; next_done = 1'b0;
    p10 = {4'h0, m} * 36'd10;
    p01 = {32'h0, m} * {32'h0, atfc_pkg::MUL_TENTH};
    rnd = {1'b0, m[31:8]} + {24'h0, m[7]};
    be  = e + $signed(atfc_pkg::FLT_BIAS) + $signed({9'h0, rnd[24]});
    msb = 5'h0;
    for (int i = 0; i < 20; i++) begin
      if (sif.mant[i]) msb = 5'(i);
    end
    unique case (sc)
      atfc_pkg::SC_IDLE: if (sif.start) begin
        next_neg = sif.neg;
        if (sif.mant == 20'h0) begin
          next_result = 32'h0; next_zero = 1'b1; next_ovf = 1'b0; next_done = 1'b1;
        end else begin
          next_m  = {12'h0, sif.mant} << (5'd31 - msb);
          next_e  = $signed({5'h0, msb});
          next_k  = sif.dexp;
          next_sc = atfc_pkg::SC_STEP;
        end
      end
      atfc_pkg::SC_STEP: begin
        if (k > 8'sd0) begin
          next_m = p10[35] ? p10[35:4] : p10[34:3];
          next_e = e + (p10[35] ? 10'sd4 : 10'sd3);
          next_k = k - 8'sd1;
        end else if (k < 8'sd0) begin
          next_m = p01[63] ? p01[63:32] : {p01[62:32], p01[31]};
          next_e = e - (p01[63] ? 10'sd3 : 10'sd4);
          next_k = k + 8'sd1;
        end else begin
          next_sc = atfc_pkg::SC_PACK;
        end
      end
      atfc_pkg::SC_PACK: begin
        next_done = 1'b1;
        next_sc   = atfc_pkg::SC_IDLE;
        next_ovf  = be >= $signed(atfc_pkg::FLT_EMAX);
        next_zero = be <= 10'sd0;
        if (be >= $signed(atfc_pkg::FLT_EMAX) || be <= 10'sd0)
          next_result = 32'h0; // underflow flushes to zero
        else
          next_result = {neg, be[7:0], rnd[22:0]};
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sc <= atfc_pkg::SC_IDLE; m <= 32'h0; e <= 10'sd0; k <= 8'sd0; neg <= 1'b0;
      result <= 32'h0; ovf <= 1'b0; zero <= 1'b0; done <= 1'b0;
    end else if (ce_i) begin
      sc <= next_sc; m <= next_m; e <= next_e; k <= next_k; neg <= next_neg;
      result <= next_result; ovf <= next_ovf; zero <= next_zero; done <= next_done;
    end
  end

  assign sif.done   = done;
  assign sif.result = result;
  assign sif.ovf    = ovf;
  assign sif.zero   = zero;
endmodule

// >>> verif/atfc_core_model.sv
// partner model: instruction core holding source words and taking result writes
`timescale 1ns/1ps
module atfc_core_model (
  // clock, reset, pacing
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        slow_i,
  // source word reads
  input  wire logic        rd_i,
  input  wire logic [3:0]  addr_i,
  output logic             valid_o,
  output logic [15:0]      data_o,
  // destination word writes
  input  wire logic        wr_i,
  input  wire logic        sel_i,
  input  wire logic [15:0] wdata_i
);
  logic [15:0] mem [16];
  logic [31:0] dst;
  int          n_rd;
  int          n_wr;
  int          cnt;

  initial begin
    valid_o = 1'b0;
    data_o  = 16'h5a5a;
    dst     = 32'h0;
    n_rd    = 0;
    n_wr    = 0;
    cnt     = 0;
  end

  // mem holds the earlier character in the high byte; the bench fills it
  always @(posedge clk_i) begin
    valid_o <= 1'b0;
    // a released data bus must not keep showing the last word
    data_o  <= ~data_o;
    if (rst_i) begin
      cnt <= 0;
    end else if (rd_i && !valid_o) begin
      if (slow_i && cnt < 3) begin
        cnt <= cnt + 1;
      end else begin
        valid_o <= 1'b1;
        data_o  <= mem[addr_i];
        cnt     <= 0;
      end
    end
    if (rd_i && valid_o) begin
      n_rd <= n_rd + 1;
    end
    if (wr_i) begin
      if (sel_i) begin
        dst[31:16] <= wdata_i;
      end else begin
        dst[15:0] <= wdata_i;
      end
      n_wr <= n_wr + 1;
    end
  end
endmodule

// >>> verif/ascii_to_float_converter_tb_top.sv
// testbench: text to float conversions, error cases and flags
`timescale 1ns/1ps
module ascii_to_float_converter_tb_top;
  logic        clk;
  logic        rst;
  logic        ce;
  logic        start;
  logic        slow;
  logic        busy;
  logic        done;
  logic        rd;
  logic [3:0]  addr;
  logic        valid;
  logic [15:0] sdata;
  logic        wr;
  logic        sel;
  logic [15:0] wdata;
  logic        err;
  logic        zero;
  int          bad_count;
  int          n_checks;
  int          cyc;
  int          last_rd;

  atfc_top DUT (
    .CLK_I              (clk),
    .SYS_RST_I          (rst),
    .CE_I               (ce),
    .START_I            (start),
    .BUSY_O             (busy),
    .DONE_O             (done),
    .SRC_RD_O           (rd),
    .SRC_ADDR_O         (addr),
    .SRC_VALID_I        (valid),
    .SRC_DATA_I         (sdata),
    .DST_WR_O           (wr),
    .DST_SEL_O          (sel),
    .DST_DATA_O         (wdata),
    .ERROR_FLAG_OUT_O   (err),
    .ZERO_RESULT_FLAG_O (zero)
  );

  atfc_core_model core (
    .clk_i   (clk),
    .rst_i   (rst),
    .slow_i  (slow),
    .rd_i    (rd),
    .addr_i  (addr),
    .valid_o (valid),
    .data_o  (sdata),
    .wr_i    (wr),
    .sel_i   (sel),
    .wdata_i (wdata)
  );

  always #4 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // '#' stands for a 00 byte so that text after a terminator can be placed
  function automatic logic [7:0] pick(input string s, input int i);
    if (i >= s.len() || s[i] == "#") begin
      return 8'h00;
    end
    return s[i];
  endfunction

  task automatic run(input string s, input logic [31:0] ev, input logic ee, input logic ez);
    int          rd0;
    int          wr0;
    logic [31:0] d0;
    int          k;
    for (int i = 0; i < 16; i++) begin
      core.mem[i] = {pick(s, 2 * i), pick(s, 2 * i + 1)};
    end
    rd0 = core.n_rd;
    wr0 = core.n_wr;
    d0  = core.dst;
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1;
    k = 0;
    while (done !== 1'b1 && k < 500) begin
      @(posedge clk);
      #1;
      k++;
    end
    check(k < 500, 1'b1, "done seen");
    check(err, ee, "error flag");
    check(zero, ez, "zero flag");
    check(core.n_wr - wr0, ee ? 2'd0 : 2'd2, "write count");
    check(core.dst, ee ? d0 : ev, "result words");
    last_rd = core.n_rd - rd0;
  endtask

  task automatic t_reset();
    check({busy, done, rd, wr, err, zero}, 6'h00, "reset outputs");
    $display("test reset done");
  endtask

  task automatic t_decimal();
    run("1.5", 32'h3fc00000, 1'b0, 1'b0);
    run("-2.5", 32'hc0200000, 1'b0, 1'b0);
    run(" 2.5", 32'h40200000, 1'b0, 1'b0);
    run("1234567", 32'h4996b400, 1'b0, 1'b0);
    $display("test decimal done");
  endtask

  task automatic t_exponent();
    slow = 1'b1;
    run("-  1.234E+02", 32'hc2f6cccd, 1'b0, 1'b0);
    run("+2.5E-01", 32'h3e800000, 1'b0, 1'b0);
    slow = 1'b0;
    $display("test exponent done");
  endtask

  task automatic t_term();
    string s;
    run("2#9.5", 32'h40000000, 1'b0, 1'b0);
    check(last_rd, 1, "words read");
    s = "1";
    for (int i = 0; i < 23; i++) begin
      s = {s, " "};
    end
    run({s, "#"}, 32'h3f800000, 1'b0, 1'b0);
    s = "1.";
    for (int i = 0; i < 30; i++) begin
      s = {s, "0"};
    end
    run(s, 32'h0, 1'b1, 1'b0);
    $display("test terminator done");
  endtask

  task automatic t_errors();
    run("1A", 32'h0, 1'b1, 1'b0);
    run("1E2", 32'h0, 1'b1, 1'b0);
    run("1E+2E+1", 32'h0, 1'b1, 1'b0);
    run("9E+99", 32'h0, 1'b1, 1'b0);
    run("-9E+99", 32'h0, 1'b1, 1'b0);
    run("#", 32'h0, 1'b1, 1'b0);
    run("1.5", 32'h3fc00000, 1'b0, 1'b0);
    $display("test errors done");
  endtask

  task automatic t_zero();
    run("0", 32'h0, 1'b0, 1'b1);
    run("-0.0", 32'h0, 1'b0, 1'b1);
    run("3", 32'h40400000, 1'b0, 1'b0);
    $display("test zero done");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    clk       = 1'b0;
    rst       = 1'b1;
    ce        = 1'b1;
    start     = 1'b0;
    slow      = 1'b0;
    bad_count = 0;
    n_checks  = 0;
    cyc       = 0;
    last_rd   = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_decimal();
    t_exponent();
    t_term();
    t_errors();
    t_zero();
    complete_run();
  end
endmodule
